// >>> rtl/fac_regs.svh
// constants of the file access command handler: command codes, limits and
// the error codes carried in a negative answer.
// assumes nothing of its surroundings; included by every design file except the package.
`ifndef FAC_REGS_SVH
`define FAC_REGS_SVH

// command codes as they arrive in the parsed request
`define FAC_CMD_SEARCH    16'h0203
`define FAC_CMD_READ      16'h0206
`define FAC_CMD_CREATE    16'h1202
`define FAC_CMD_WRITE     16'h1203

// largest byte count of one read or write
`define FAC_MAX_XFER      16'h03C0

// accepted frame formats
`define FAC_FMT_MIN       3'h1
`define FAC_FMT_MAX       3'h5

// error codes of a negative answer
`define FAC_ERR_NONE      8'h00
`define FAC_ERR_NOFILE    8'h01
`define FAC_ERR_RANGE     8'h02
`define FAC_ERR_UNWRITTEN 8'h03
`define FAC_ERR_NOSPACE   8'h04
`define FAC_ERR_BADCMD    8'h05
`define FAC_ERR_BADFMT    8'h06
`define FAC_ERR_EXISTS    8'h07

`endif

// >>> rtl/fac_pkg.sv
// types shared by the file access command handler and its testbench.
// assumes the framing layer has already decoded one request into fac_cmd_t.
package fac_pkg;

  // one decoded request
  typedef struct packed {
    logic [15:0] code;    // command code
    logic [2:0]  fmt;     // frame format the request came in
    logic        ascii;   // 1: ascii coded, 0: binary coded
    logic [7:0]  fnum;    // file slot number
    logic [7:0]  attr;    // attribute field, never interpreted
    logic [15:0] offset;  // byte offset into the file
    logic [15:0] nbytes;  // byte count of a read or write
    logic [15:0] fsize;   // file size for create
  } fac_cmd_t;

  // one answer
  typedef struct packed {
    logic        nak;     // 1: negative answer
    logic [7:0]  err;     // error code, zero on a positive answer
    logic [15:0] code;    // command code being answered
    logic [15:0] fsize;   // size of the file named
    logic [31:0] mtime;   // creation time of the file named; writes do not restamp it
  } fac_resp_t;

  // handler states
  typedef enum logic [1:0] {
    FAC_IDLE,
    FAC_RD,
    FAC_WR,
    FAC_RESP
  } fac_state_t;

endpackage

// >>> rtl/fac_buf.sv
// small valid/ready buffer in front of the read data output.
// assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
`include "fac_regs.svh"

module fac_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_r [DEPTH];   // storage entries
  logic [PW-1:0] wp_r, wp_nxt;   // write index
  logic [PW-1:0] rp_r, rp_nxt;   // read index
  logic [PW:0]   cnt_r, cnt_nxt; // entries held
  logic          push, pop;

  // step an index with wrap, used by both pointers
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // full and empty come straight from the count, so back-pressure is honest
  always_comb begin
    in_ready_o  = (cnt_r != (PW+1)'(DEPTH));
    out_valid_o = (cnt_r != '0);
    out_data_o  = mem_r[rp_r];
    push        = in_valid_i & in_ready_o;
    pop         = out_valid_o & out_ready_i;
    wp_nxt      = push ? step(wp_r) : wp_r;
    rp_nxt      = pop ? step(rp_r) : rp_r;
    cnt_nxt     = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (PW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (PW+1)'(cnt_r - 1'b1);
    end
  end

  // registers only; the data array is not reset since empty masks it
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

endmodule

// >>> rtl/fac_handler.sv
// file access command handler: search, read, create and write on a small
// file store held in flip-flops.
// assumes requests arrive already deframed as fac_cmd_t, one at a time,
// and that mgmt_time_i carries the device's running management time.
`timescale 1ns/1ps
`include "fac_regs.svh"

// How it works
// - missing file on search gives negative answer
// - read command returns bytes from offset
// - byte count limited to 960 per command
// - attribute field ignored on read and search
// - create registers file, reserves free space
// - never written file refuses reads
// - create stamps file with management time
// - write command stores bytes from offset
// - formats one to five, ascii or binary
module fac_handler #(
  parameter int NF        = 4,     // number of file slots
  parameter int MEM_BYTES = 1024   // bytes of file storage
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire fac_pkg::fac_cmd_t cmd_i,
  input  wire logic             cmd_valid_i,
  output logic                  cmd_ready_o,
  input  wire logic [31:0]      mgmt_time_i,
  input  wire logic [7:0]       wdat_i,
  input  wire logic             wdat_valid_i,
  output logic                  wdat_ready_o,
  output logic [7:0]            rdat_o,
  output logic                  rdat_valid_o,
  input  wire logic             rdat_ready_i,
  output fac_pkg::fac_resp_t    resp_o,
  output logic                  resp_valid_o,
  input  wire logic             resp_ready_i
);
  import fac_pkg::*;

  localparam int AW = $clog2(MEM_BYTES);

  fac_state_t   st_r, st_nxt;             // handler state
  logic [7:0]   mem_r [MEM_BYTES];        // file bytes
  logic         exist_r [NF];             // slot holds a file
  logic         wrtn_r [NF];              // file has received data
  logic [15:0]  size_r [NF];              // file size
  logic [AW-1:0] base_r [NF];             // first byte of file area
  logic [31:0]  time_r [NF];              // time stamped at create, kept through writes
  logic [AW:0]  free_r, free_nxt;         // first unallocated byte
  logic [AW-1:0] addr_r, addr_nxt;        // current byte address
  logic [15:0]  cnt_r, cnt_nxt;           // bytes left to move
  logic [7:0]   slot_r, slot_nxt;         // slot being served
  fac_resp_t    resp_r, resp_nxt;         // pending answer
  // table and memory updates, registered by the clocked process
  logic         tbl_new, tbl_wrtn, mem_we;
  logic [15:0]  tbl_size;
  logic [AW-1:0] tbl_base;
  logic [31:0]  tbl_time;
  // read stream into the buffer
  logic         bin_valid, bin_ready;
  logic         hit;
  logic [AW-1:0] fbase;
  logic [15:0]  fsize;

  // even offset, count within limit, whole span inside the file
  function automatic logic in_range(input logic [15:0] off, input logic [15:0] n,
                                    input logic [15:0] sz);
    in_range = (off[0] == 1'b0) && (n <= `FAC_MAX_XFER) && (off < sz) &&
               (({1'b0, off} + {1'b0, n}) <= {1'b0, sz});
  endfunction

  // file address of a byte; the span check keeps the sum inside the area
  function automatic logic [AW-1:0] faddr(input logic [AW-1:0] b, input logic [15:0] off);
    faddr = AW'(b + off[AW-1:0]);
  endfunction

  // fill an answer record
  function automatic fac_resp_t mk_resp(input logic nak, input logic [7:0] err,
                                        input logic [15:0] code, input logic [15:0] sz,
                                        input logic [31:0] tm);
    mk_resp.nak   = nak;
    mk_resp.err   = err;
    mk_resp.code  = code;
    mk_resp.fsize = sz;
    mk_resp.mtime = tm;
  endfunction

  // slot lookup for the request on the input; out of range slots never hit
  always_comb begin
    hit   = 1'b0;
    fbase = '0;
    fsize = '0;
    if (int'(cmd_i.fnum) < NF) begin
      hit   = exist_r[cmd_i.fnum[$clog2(NF)-1:0]];
      fbase = base_r[cmd_i.fnum[$clog2(NF)-1:0]];
      fsize = size_r[cmd_i.fnum[$clog2(NF)-1:0]];
    end
  end

  // command decode and data movement
  always_comb begin
    st_nxt    = st_r;
    free_nxt  = free_r;
    addr_nxt  = addr_r;
    cnt_nxt   = cnt_r;
    slot_nxt  = slot_r;
    resp_nxt  = resp_r;
    tbl_new   = 1'b0;
    tbl_wrtn  = 1'b0;
    tbl_size  = cmd_i.fsize;
    tbl_base  = free_r[AW-1:0];
    tbl_time  = mgmt_time_i;
    mem_we    = 1'b0;
    bin_valid = 1'b0;
    case (st_r)
      FAC_IDLE: begin
        if (cmd_valid_i) begin
          slot_nxt = cmd_i.fnum;
          st_nxt   = FAC_RESP;
          // the attribute field is never looked at below
          // format range check
          if (cmd_i.fmt < `FAC_FMT_MIN || cmd_i.fmt > `FAC_FMT_MAX) begin
            resp_nxt = mk_resp(1'b1, `FAC_ERR_BADFMT, cmd_i.code, 16'h0000, 32'h0000_0000);
          end else if (cmd_i.code == `FAC_CMD_SEARCH) begin
            if (!hit) begin
              resp_nxt = mk_resp(1'b1, `FAC_ERR_NOFILE, cmd_i.code, 16'h0000, 32'h0000_0000);
            end else begin
              resp_nxt = mk_resp(1'b0, `FAC_ERR_NONE, cmd_i.code, fsize,
                                 time_r[cmd_i.fnum[$clog2(NF)-1:0]]);
            end
          end else if (cmd_i.code == `FAC_CMD_READ) begin
            if (!hit) begin
              resp_nxt = mk_resp(1'b1, `FAC_ERR_NOFILE, cmd_i.code, 16'h0000, 32'h0000_0000);
            end else if (!wrtn_r[cmd_i.fnum[$clog2(NF)-1:0]]) begin
              resp_nxt = mk_resp(1'b1, `FAC_ERR_UNWRITTEN, cmd_i.code, fsize, 32'h0000_0000);
            end else if (!in_range(cmd_i.offset, cmd_i.nbytes, fsize)) begin
              resp_nxt = mk_resp(1'b1, `FAC_ERR_RANGE, cmd_i.code, fsize, 32'h0000_0000);
            end else begin
              addr_nxt = faddr(fbase, cmd_i.offset);
              cnt_nxt  = cmd_i.nbytes;
              resp_nxt = mk_resp(1'b0, `FAC_ERR_NONE, cmd_i.code, fsize,
                                 time_r[cmd_i.fnum[$clog2(NF)-1:0]]);
              st_nxt   = FAC_RD;
            end
          end else if (cmd_i.code == `FAC_CMD_CREATE) begin
            if (int'(cmd_i.fnum) >= NF) begin
              resp_nxt = mk_resp(1'b1, `FAC_ERR_NOFILE, cmd_i.code, 16'h0000, 32'h0000_0000);
            end else if (hit) begin
              resp_nxt = mk_resp(1'b1, `FAC_ERR_EXISTS, cmd_i.code, fsize, 32'h0000_0000);
            end else if (int'(cmd_i.fsize) > MEM_BYTES - int'(free_r)) begin
              resp_nxt = mk_resp(1'b1, `FAC_ERR_NOSPACE, cmd_i.code, cmd_i.fsize, 32'h0000_0000);
            end else begin
              tbl_new  = 1'b1;
              free_nxt = (AW+1)'(free_r + cmd_i.fsize);
              resp_nxt = mk_resp(1'b0, `FAC_ERR_NONE, cmd_i.code, cmd_i.fsize, mgmt_time_i);
            end
          end else if (cmd_i.code == `FAC_CMD_WRITE) begin
            if (!hit) begin
              resp_nxt = mk_resp(1'b1, `FAC_ERR_NOFILE, cmd_i.code, 16'h0000, 32'h0000_0000);
            end else if (!in_range(cmd_i.offset, cmd_i.nbytes, fsize)) begin
              resp_nxt = mk_resp(1'b1, `FAC_ERR_RANGE, cmd_i.code, fsize, 32'h0000_0000);
            end else begin
              addr_nxt = faddr(fbase, cmd_i.offset);
              cnt_nxt  = cmd_i.nbytes;
              resp_nxt = mk_resp(1'b0, `FAC_ERR_NONE, cmd_i.code, fsize,
                                 time_r[cmd_i.fnum[$clog2(NF)-1:0]]);
              st_nxt   = FAC_WR;
            end
          end else begin
            // unknown code: refuse rather than guess
            resp_nxt = mk_resp(1'b1, `FAC_ERR_BADCMD, cmd_i.code, 16'h0000, 32'h0000_0000);
          end
        end
      end
      FAC_RD: begin
        // stream bytes; the buffer absorbs receiver stalls
        bin_valid = (cnt_r != 16'h0000);
        if (cnt_r == 16'h0000) begin
          st_nxt = FAC_RESP;
        end else if (bin_ready) begin
          addr_nxt = AW'(addr_r + 1'b1);
          cnt_nxt  = 16'(cnt_r - 1'b1);
        end
      end
      FAC_WR: begin
        if (cnt_r == 16'h0000) begin
          tbl_wrtn = 1'b1;
          st_nxt   = FAC_RESP;
        end else if (wdat_valid_i) begin
          mem_we   = 1'b1;
          addr_nxt = AW'(addr_r + 1'b1);
          cnt_nxt  = 16'(cnt_r - 1'b1);
        end
      end
      FAC_RESP: begin
        // answer held until taken
        if (resp_ready_i) begin
          st_nxt = FAC_IDLE;
        end
      end
      default: st_nxt = FAC_IDLE;
    endcase
  end

  // handshake outputs straight from state
  always_comb begin
    cmd_ready_o  = (st_r == FAC_IDLE);
    wdat_ready_o = (st_r == FAC_WR) && (cnt_r != 16'h0000);
    resp_valid_o = (st_r == FAC_RESP);
    resp_o       = resp_r;
  end

  // registers only; file bytes are not reset, the written flag guards them
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r   <= FAC_IDLE;
      free_r <= '0;
      addr_r <= '0;
      cnt_r  <= 16'h0000;
      slot_r <= 8'h00;
      resp_r <= '0;
      for (int i = 0; i < NF; i++) begin
        exist_r[i] <= 1'b0;
        wrtn_r[i]  <= 1'b0;
        size_r[i]  <= 16'h0000;
        base_r[i]  <= '0;
        time_r[i]  <= 32'h0000_0000;
      end
    end else begin
      st_r   <= st_nxt;
      free_r <= free_nxt;
      addr_r <= addr_nxt;
      cnt_r  <= cnt_nxt;
      slot_r <= slot_nxt;
      resp_r <= resp_nxt;
      if (tbl_new) begin
        exist_r[cmd_i.fnum[$clog2(NF)-1:0]] <= 1'b1;
        wrtn_r[cmd_i.fnum[$clog2(NF)-1:0]]  <= 1'b0;
        size_r[cmd_i.fnum[$clog2(NF)-1:0]]  <= tbl_size;
        base_r[cmd_i.fnum[$clog2(NF)-1:0]]  <= tbl_base;
        time_r[cmd_i.fnum[$clog2(NF)-1:0]]  <= tbl_time;
      end
      if (tbl_wrtn) begin
        wrtn_r[slot_r[$clog2(NF)-1:0]] <= 1'b1;
      end
    end
    if (mem_we) begin
      mem_r[addr_r] <= wdat_i;
    end
  end

  // read data buffer; a stall downstream freezes the read counter
  fac_buf #(
    .W     (8),
    .DEPTH (2)
  ) u_rbuf (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_data_i   (mem_r[addr_r]),
    .in_valid_i  (bin_valid),
    .in_ready_o  (bin_ready),
    .out_data_o  (rdat_o),
    .out_valid_o (rdat_valid_o),
    .out_ready_i (rdat_ready_i)
  );

endmodule

// >>> tb/fac_handler_asserts.sv
// concurrent checks on the ports of the file access command handler.
// assumes one clock, mclk_i, and a synchronous active high reset, rst_i.
`timescale 1ns/1ps
`include "fac_regs.svh"

module fac_handler_asserts
  import fac_pkg::*;
#(
  parameter int NF        = 4,
  parameter int MEM_BYTES = 1024
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire fac_cmd_t    cmd_i,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_ready_o,
  input  wire logic [31:0] mgmt_time_i,
  input  wire logic [7:0]  wdat_i,
  input  wire logic        wdat_valid_i,
  input  wire logic        wdat_ready_o,
  input  wire logic [7:0]  rdat_o,
  input  wire logic        rdat_valid_o,
  input  wire logic        rdat_ready_i,
  input  wire fac_resp_t   resp_o,
  input  wire logic        resp_valid_o,
  input  wire logic        resp_ready_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  logic fmt_ok;  // request came in one of the accepted frame formats
  assign fmt_ok = (cmd_i.fmt >= `FAC_FMT_MIN) && (cmd_i.fmt <= `FAC_FMT_MAX);

  // a request is taken; the coded form also asks for a good format
  sequence s_take;
    cmd_valid_i && cmd_ready_o;
  endsequence
  sequence s_take_ok(c);
    s_take ##0 (fmt_ok && cmd_i.code == c);
  endsequence

  property p_bad_fmt;
    s_take ##0 !fmt_ok |=> resp_valid_o && resp_o.nak && resp_o.err == `FAC_ERR_BADFMT;
  endproperty
  a_bad_fmt: assert property (p_bad_fmt) else $error("bad format not refused");

  property p_search;
    s_take_ok(`FAC_CMD_SEARCH) |=> resp_valid_o && (!resp_o.nak || resp_o.err == `FAC_ERR_NOFILE);
  endproperty
  a_search: assert property (p_search) else $error("search answer wrong");

  property p_create;
    s_take_ok(`FAC_CMD_CREATE) |=> resp_valid_o && resp_o.code == `FAC_CMD_CREATE && (resp_o.nak ||
      (resp_o.mtime == $past(mgmt_time_i) && resp_o.fsize == $past(cmd_i.fsize)));
  endproperty
  a_create: assert property (p_create) else $error("create answer wrong");

  property p_rd_range;
    s_take_ok(`FAC_CMD_READ) ##0 (cmd_i.offset[0] || cmd_i.nbytes > `FAC_MAX_XFER) |=> resp_valid_o && resp_o.nak;
  endproperty
  a_rd_range: assert property (p_rd_range) else $error("bad read range accepted");

  property p_nak_quiet;
    resp_valid_o && resp_o.nak |-> !$rose(rdat_valid_o) && !wdat_ready_o;
  endproperty
  a_nak_quiet: assert property (p_nak_quiet) else $error("data moved on a refusal");

  property p_resp_hold;
    resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable(resp_o);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("answer dropped early");

  property p_release;
    resp_valid_o && resp_ready_i |=> !resp_valid_o && cmd_ready_o;
  endproperty
  a_release: assert property (p_release) else $error("no return to idle");

  property p_busy;
    resp_valid_o || wdat_ready_o |-> !cmd_ready_o;
  endproperty
  a_busy: assert property (p_busy) else $error("request taken while busy");

  property p_rd_hold;
    rdat_valid_o && !rdat_ready_i |=> rdat_valid_o && $stable(rdat_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read byte lost in stall");
endmodule

// >>> tb/fac_host_rx.sv
// host side model: takes read bytes from the handler, promptly or slowly.
// assumes one clock; ready changes just after a falling edge.
`timescale 1ns/1ps

module fac_host_rx (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       stall_i,
  input  wire logic [7:0] rdat_i,
  input  wire logic       rdat_valid_i,
  output logic            rdat_ready_o
);
  logic [7:0] q [$];  // bytes received, in arrival order
  logic [1:0] cnt_r;  // stall pattern counter

  // slow mode takes one byte in four so the buffer backs up; reset clears the pattern
  always @(negedge mclk_i) begin
    cnt_r        <= rst_i ? 2'h0 : cnt_r + 2'h1;
    rdat_ready_o <= !rst_i && (!stall_i || cnt_r == 2'h0);
  end

  always @(posedge mclk_i) begin
    if (!rst_i && rdat_valid_i && rdat_ready_o) q.push_back(rdat_i);
  end
endmodule

// >>> tb/fac_handler_bench.sv
// self-checking bench for the file access command handler.
// assumes the host model fac_host_rx and the checker fac_handler_asserts.
`timescale 1ns/1ps
`include "fac_regs.svh"

module fac_handler_bench;
  import fac_pkg::*;
  logic        mclk_i, rst_i, cmd_valid_i, wdat_valid_i, rdat_ready_i, resp_ready_i;
  logic        cmd_ready_o, wdat_ready_o, rdat_valid_o, resp_valid_o, rx_stall, asc;
  fac_cmd_t    cmd_i;
  fac_resp_t   resp_o, last_r;
  logic [31:0] mgmt_time_i;
  logic [7:0]  wdat_i, rdat_o, attr_v;
  logic [7:0]  fm [0:1][0:959];  // expected file contents of slots 0 and 1
  int          n_mismatch = 0, check_count = 0, cyc = 0;

  fac_handler #(.NF(4), .MEM_BYTES(1024)) uut (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_i(cmd_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .mgmt_time_i(mgmt_time_i), .wdat_i(wdat_i),
    .wdat_valid_i(wdat_valid_i), .wdat_ready_o(wdat_ready_o), .rdat_o(rdat_o), .rdat_valid_o(rdat_valid_o),
    .rdat_ready_i(rdat_ready_i), .resp_o(resp_o), .resp_valid_o(resp_valid_o), .resp_ready_i(resp_ready_i));
  fac_host_rx rx (.mclk_i(mclk_i), .rst_i(rst_i), .stall_i(rx_stall), .rdat_i(rdat_o),
    .rdat_valid_i(rdat_valid_o), .rdat_ready_o(rdat_ready_i));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // hang guard, far above the longest run of stalled reads
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held from a falling edge until the edge that takes it
  task automatic send(input logic [15:0] code, input logic [2:0] fmt, input logic [7:0] fnum,
                      input logic [15:0] off, input logic [15:0] nb, input logic [15:0] fsz);
    int k;
    k = 0;
    cmd_i       = {code, fmt, asc, fnum, attr_v, off, nb, fsz};
    cmd_valid_i = 1'b1;
    while (!cmd_ready_o && k < 100) begin
      @(negedge mclk_i);
      k++;
    end
    // a wait that runs out counts as a mismatch here
    check("cmd_ready", cmd_ready_o, 1'b1);
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
  endtask

  // waits for the answer, judges it, then takes it
  task automatic expect_resp(input logic nak, input logic [7:0] err);
    int k;
    k = 0;
    while (!resp_valid_o && k < 5000) begin
      @(negedge mclk_i);
      k++;
    end
    last_r = resp_o;
    check("answer_valid", resp_valid_o, 1'b1);
    check("answer", {23'h0, last_r.nak, last_r.err}, {23'h0, nak, err});
    resp_ready_i = 1'b1;
    @(negedge mclk_i);
    resp_ready_i = 1'b0;
  endtask

  task automatic write_file(input logic [7:0] slot, input int off, input int n, input logic [7:0] base);
    int k;
    send(`FAC_CMD_WRITE, 3'h1, slot, off[15:0], n[15:0], 16'h0000);
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (!wdat_ready_o && k < 50) begin
        @(negedge mclk_i);
        k++;
      end
      check("wdat_ready", wdat_ready_o, 1'b1);
      fm[slot[0]][off+i] = base + i[7:0];
      wdat_i       = base + i[7:0];
      wdat_valid_i = 1'b1;
      @(negedge mclk_i);
    end
    wdat_valid_i = 1'b0;
    expect_resp(1'b0, `FAC_ERR_NONE);
  endtask

  task automatic read_chk(input logic [7:0] slot, input int off, input int n, input logic stall);
    int k;
    k = 0;
    rx_stall = stall;
    rx.q.delete();
    send(`FAC_CMD_READ, 3'h5, slot, off[15:0], n[15:0], 16'h0000);
    expect_resp(1'b0, `FAC_ERR_NONE);
    while (rx.q.size() < n && k < 100) begin
      @(negedge mclk_i);
      k++;
    end
    check("read_count", rx.q.size(), n);
    for (int i = 0; i < n; i++) check("read_byte", rx.q[i], fm[slot[0]][off+i]);
  endtask

  task automatic sc_missing();
    send(`FAC_CMD_SEARCH, 3'h1, 8'h00, 16'h0000, 16'h0000, 16'h0000);
    expect_resp(1'b1, `FAC_ERR_NOFILE);
    send(`FAC_CMD_READ, 3'h1, 8'h02, 16'h0000, 16'h0002, 16'h0000);
    expect_resp(1'b1, `FAC_ERR_NOFILE);
  endtask

  task automatic sc_create();
    mgmt_time_i = 32'h1234_5678;
    send(`FAC_CMD_CREATE, 3'h1, 8'h00, 16'h0000, 16'h0000, 16'h0010);
    expect_resp(1'b0, `FAC_ERR_NONE);
    check("create_time", last_r.mtime, 32'h1234_5678);
    check("create_size", last_r.fsize, 32'h0000_0010);
    mgmt_time_i = 32'h0BAD_F00D;
    send(`FAC_CMD_CREATE, 3'h5, 8'h01, 16'h0000, 16'h0000, 16'h03C0);
    expect_resp(1'b0, `FAC_ERR_NONE);
    check("create_time", last_r.mtime, 32'h0BAD_F00D);
    send(`FAC_CMD_CREATE, 3'h1, 8'h02, 16'h0000, 16'h0000, 16'h0100);
    expect_resp(1'b1, `FAC_ERR_NOSPACE);
    send(`FAC_CMD_CREATE, 3'h1, 8'h00, 16'h0000, 16'h0000, 16'h0010);
    expect_resp(1'b1, `FAC_ERR_EXISTS);
    send(`FAC_CMD_READ, 3'h1, 8'h00, 16'h0000, 16'h0002, 16'h0000);
    expect_resp(1'b1, `FAC_ERR_UNWRITTEN);
  endtask

  // data written, then read back in parts, the host stalling on some reads
  task automatic sc_data();
    write_file(8'h00, 0, 16, 8'h11);
    write_file(8'h01, 0, 960, 8'h40);
    attr_v = 8'hA5;
    read_chk(8'h00, 0, 8, 1'b0);
    read_chk(8'h00, 8, 8, 1'b1);
    read_chk(8'h00, 4, 0, 1'b0);
    read_chk(8'h01, 0, 960, 1'b1);
    attr_v = 8'h20;
  endtask

  // odd offset, offset at size, span past size, count above limit
  task automatic sc_range();
    rx.q.delete();
    send(`FAC_CMD_READ, 3'h1, 8'h00, 16'h0001, 16'h0002, 16'h0000);
    expect_resp(1'b1, `FAC_ERR_RANGE);
    send(`FAC_CMD_READ, 3'h1, 8'h00, 16'h0010, 16'h0000, 16'h0000);
    expect_resp(1'b1, `FAC_ERR_RANGE);
    send(`FAC_CMD_READ, 3'h1, 8'h00, 16'h0000, 16'h0011, 16'h0000);
    expect_resp(1'b1, `FAC_ERR_RANGE);
    send(`FAC_CMD_READ, 3'h1, 8'h01, 16'h0000, 16'h03C1, 16'h0000);
    expect_resp(1'b1, `FAC_ERR_RANGE);
    repeat (4) @(negedge mclk_i);
    check("refused_bytes", rx.q.size(), 0);
  endtask

  task automatic sc_formats();
    for (int f = 0; f < 8; f++) begin
      for (int a = 0; a < 2; a++) begin
        asc = a[0];
        send(`FAC_CMD_SEARCH, f[2:0], 8'h00, 16'h0000, 16'h0000, 16'h0000);
        if (f >= 1 && f <= 5) begin
          expect_resp(1'b0, `FAC_ERR_NONE);
          check("search_size", last_r.fsize, 32'h0000_0010);
        end else begin
          expect_resp(1'b1, `FAC_ERR_BADFMT);
        end
      end
    end
  endtask

  initial begin
    rst_i        = 1'b1;
    cmd_valid_i  = 1'b0;
    cmd_i        = '0;
    mgmt_time_i  = 32'h0000_0000;
    wdat_i       = 8'h00;
    wdat_valid_i = 1'b0;
    resp_ready_i = 1'b0;
    rx_stall     = 1'b0;
    asc          = 1'b1;
    attr_v       = 8'h20;
    repeat (6) @(negedge mclk_i);
    rst_i = 1'b0;
    sc_missing();
    sc_create();
    sc_data();
    sc_range();
    sc_formats();
    test_done();
  end
endmodule

bind fac_handler fac_handler_asserts #(.NF(NF), .MEM_BYTES(MEM_BYTES)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .mgmt_time_i(mgmt_time_i),
  .wdat_i(wdat_i), .wdat_valid_i(wdat_valid_i), .wdat_ready_o(wdat_ready_o), .rdat_o(rdat_o),
  .rdat_valid_o(rdat_valid_o), .rdat_ready_i(rdat_ready_i), .resp_o(resp_o), .resp_valid_o(resp_valid_o),
  .resp_ready_i(resp_ready_i));
